// *** dcf_defines.vh ***
`ifndef DCF_DEFINES_VH
`define DCF_DEFINES_VH

// store geometry
`define DCF_WIDTH 36
`define DCF_DEPTH 7'h40
`define DCF_PTR_W 6
`define DCF_CNT_W 7

// apb register byte addresses
`define DCF_ADDR_CTRL 12'h000
`define DCF_ADDR_STAT 12'h004

// control register fields and reset value
`define DCF_CTRL_ODD 0
`define DCF_CTRL_RST 1'h0

// status register fields
`define DCF_ST_CNT_MSB 6
`define DCF_ST_CNT_LSB 0
`define DCF_ST_FULL 8
`define DCF_ST_EMPTY 9
`define DCF_ST_AFULL 10
`define DCF_ST_AEMPTY 11
`define DCF_ST_A_TO_B_MAIL_FLAG_N 12
`define DCF_ST_B_TO_A_MAIL_FLAG_N 13
`define DCF_ST_OFS_MSB 20
`define DCF_ST_OFS_LSB 16

// almost flag offsets, indexed by {offset_select_hi, offset_select_lo}
`define DCF_OFS_HH 5'h10
`define DCF_OFS_HL 5'h0c
`define DCF_OFS_LH 5'h08
`define DCF_OFS_LL 5'h04
`define DCF_OFS_RST 5'h04

// pclk cycles after reset release before the offset selects are taken
`define DCF_CAP_DELAY 2'h2

// port-b bus size codes {bus_size_sel_hi, bus_size_sel_lo}
`define DCF_SIZE_LONG 2'h0
`define DCF_SIZE_WORD 2'h1
`define DCF_SIZE_BYTE 2'h2
`define DCF_SIZE_MAIL 2'h3

// swap codes {swap_sel_hi, swap_sel_lo}
`define DCF_SWAP_NONE 2'h0
`define DCF_SWAP_BYTE 2'h1
`define DCF_SWAP_WORD 2'h2
`define DCF_SWAP_BOTH 2'h3

`endif

// *** dcf_port_in.v ***
module dcf_port_in
#(
   parameter W = 1
)
(
   // clock and reset
   input wire pclk,
   input wire presetn,
   // pin side
   input wire port_clk,
   input wire [W-1:0] sig_in,
   // synchronised side
   output wire rise,
   output reg [W-1:0] sig_out
);

// clock pin and its qualifiers share one synchroniser so they stay aligned
reg [W:0] meta_r;
reg clk_s2_r;
reg clk_d_r;
reg [2:0] live_r;

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      meta_r <= {(W+1){1'b0}};
      clk_s2_r <= 1'b0;
      sig_out <= {W{1'b0}};
      clk_d_r <= 1'b0;
      live_r <= 3'h0;
   end
   else
   begin
      meta_r <= {port_clk, sig_in};
      {clk_s2_r, sig_out} <= meta_r;
      clk_d_r <= clk_s2_r;
      live_r <= {live_r[1:0], 1'b1};
   end
end

// edges wait until both clock flops hold sampled pin values, else a high pin fakes a rise
assign rise = clk_s2_r & ~clk_d_r & live_r[2];

endmodule

// *** dcf_mem.v ***
`include "dcf_defines.vh"

module dcf_mem
(
   // clock
   input wire pclk,
   // write side
   input wire we,
   input wire [`DCF_PTR_W-1:0] waddr,
   input wire [`DCF_WIDTH-1:0] wdata,
   // read side
   input wire [`DCF_PTR_W-1:0] raddr,
   output wire [`DCF_WIDTH-1:0] rdata
);

// no reset: contents are meaningless until written
reg [`DCF_WIDTH-1:0] mem_r [0:`DCF_DEPTH-1];

always @(posedge pclk)
begin
   if (we)
      mem_r[waddr] <= wdata;
end

assign rdata = mem_r[raddr];

endmodule

// *** dcf_top.v ***
// What this block does
// R1: a 64 by 36 store passes port-a writes to port-b reads in order.
// R2: transfers happen only on qualified rising edges of each port clock.
// R3: full and almost-full settle over two a edges, empty ones over two b edges; full and empty fall on the first.
// R4: almost-empty goes low when stored words are at or below the offset.
// R5: almost-full goes low when free locations are at or below the offset.
// R6: reset release captures the two offset selects into the offset.
// R7: empty flag low blocks reads; rises on second b edge after data.
// R8: full flag low blocks writes; rises on second a edge after reset.
// R9: port a acts only when selected and enabled; bus idle when deselected.
// R10: port b acts only when selected and enabled; bus idle when deselected.
// R11: port-a mailbox select routes to mail; port-a outputs show b-to-a mail.
// R12: a-to-b flag drops on mail write; further writes ignored while low.
// R13: a-to-b flag rises on port-b mailbox-size read, and at reset.
// R14: b-to-a flag drops on mail write; further writes ignored while low.
// R15: b-to-a flag rises on port-a mailbox read, and at reset.
// R16: port b reads out in 36, 18 or 9 bits, timed on b edges.
// R17: big endian uses upper byte lanes, little endian the lower ones.
// R18: no swap, byte swap, word swap and byte-word swap on port b.
// R19: odd parity select high means odd, low means even, check and generate.
// R20: port-a parity error low when any 9-bit lane fails parity.
// R21: port-a parity error forced high during a generating b-to-a mail read.
// R22: parity checks never block; per-port generation on read data.
// R23: reset leaves almost-full, mail and parity error flags high, others low.
// R24: offsets are 16, 12, 8 or 4 by the two selects.
// R25: a store write needs select, write, enable, no mailbox and not full.
// R26: swap mode is sampled at the start of each long-word store read.
`include "dcf_defines.vh"

module dcf_top
(
   // apb slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   // offset straps
   input wire offset_select_lo,
   input wire offset_select_hi,
   // port a
   input wire write_port_clock,
   input wire write_port_select_n,
   input wire write_port_enable,
   input wire write_port_dir,
   input wire a_side_mailbox_select,
   input wire a_side_parity_gen,
   input wire [35:0] a_side_data_bus_in,
   output reg [35:0] a_side_data_bus_out,
   output reg a_side_data_bus_oe,
   output reg full_flag_n,
   output reg almost_full_flag_n,
   output reg a_to_b_mail_flag_n,
   output reg a_side_parity_error_n,
   // port b
   input wire read_port_clock,
   input wire read_port_select_n,
   input wire read_port_enable,
   input wire read_port_dir,
   input wire bus_size_sel_lo,
   input wire bus_size_sel_hi,
   input wire endian_select_n,
   input wire swap_sel_lo,
   input wire swap_sel_hi,
   input wire b_side_parity_gen,
   input wire [35:0] b_side_data_bus_in,
   output reg [35:0] b_side_data_bus_out,
   output reg b_side_data_bus_oe,
   output reg empty_flag_n,
   output reg almost_empty_flag_n,
   output reg b_to_a_mail_flag_n,
   output reg b_side_parity_error_n
);

function [35:0] gen_par;
   input [35:0] w;
   input odd;
   integer i;
   begin
      gen_par = w;
      for (i = 0; i < 4; i = i + 1)
         gen_par[9*i+8] = (^w[9*i +: 8]) ^ odd;
   end
endfunction

function par_err;
   input [35:0] w;
   input odd;
   input [3:0] mask;
   integer i;
   begin
      par_err = 1'b0;
      for (i = 0; i < 4; i = i + 1)
         if (mask[i] && ((^w[9*i +: 9]) != odd))
            par_err = 1'b1;
   end
endfunction

function [35:0] swap;
   input [35:0] w;
   input [1:0] mode;
   begin
      case (mode)
         `DCF_SWAP_BYTE: swap = {w[8:0], w[17:9], w[26:18], w[35:27]};
         `DCF_SWAP_WORD: swap = {w[17:9], w[8:0], w[35:27], w[26:18]};
         `DCF_SWAP_BOTH: swap = {w[26:18], w[35:27], w[8:0], w[17:9]};
         default: swap = w;
      endcase
   end
endfunction

// picks the part of a long word shown by one narrow read
function [35:0] place;
   input [35:0] w;
   input [1:0] sz;
   input en_n;
   input [1:0] idx;
   reg [17:0] hf;
   reg [8:0] ln;
   reg [1:0] sel;
   begin
      hf = (idx[0] ^ en_n) ? w[17:0] : w[35:18];
      sel = en_n ? idx : ~idx;
      case (sel)
         2'h0: ln = w[8:0];
         2'h1: ln = w[17:9];
         2'h2: ln = w[26:18];
         default: ln = w[35:27];
      endcase
      case (sz)
         `DCF_SIZE_WORD: place = en_n ? {18'h0_0000, hf} : {hf, 18'h0_0000};
         `DCF_SIZE_BYTE: place = en_n ? {27'h000_0000, ln} : {ln, 27'h000_0000};
         default: place = w;
      endcase
   end
endfunction

function [1:0] last_part;
   input [1:0] sz;
   begin
      case (sz)
         `DCF_SIZE_WORD: last_part = 2'h1;
         `DCF_SIZE_BYTE: last_part = 2'h3;
         default: last_part = 2'h0;
      endcase
   end
endfunction

// synchronised port pins; selects cross inverted so a reset sync reads as deselected
wire a_rise;
wire [40:0] a_s;
wire b_rise;
wire [44:0] b_s;

dcf_port_in #(.W(41)) u_port_a
(
   .pclk(pclk),
   .presetn(presetn),
   .port_clk(write_port_clock),
   .sig_in({~write_port_select_n, write_port_enable, write_port_dir,
      a_side_mailbox_select, a_side_parity_gen, a_side_data_bus_in}),
   .rise(a_rise),
   .sig_out(a_s)
);

dcf_port_in #(.W(45)) u_port_b
(
   .pclk(pclk),
   .presetn(presetn),
   .port_clk(read_port_clock),
   .sig_in({~read_port_select_n, read_port_enable, read_port_dir,
      bus_size_sel_hi, bus_size_sel_lo, endian_select_n, swap_sel_hi,
      swap_sel_lo, b_side_parity_gen, b_side_data_bus_in}),
   .rise(b_rise),
   .sig_out(b_s)
);

wire a_sel_n = ~a_s[40];
wire a_en = a_s[39];
wire a_dir = a_s[38];
wire a_mb = a_s[37];
wire a_pg = a_s[36];
wire [35:0] a_din = a_s[35:0];
wire b_sel_n = ~b_s[44];
wire b_en = b_s[43];
wire b_dir = b_s[42];
wire [1:0] b_size = b_s[41:40];
wire b_endian_n = b_s[39];
wire [1:0] b_swap = b_s[38:37];
wire b_pg = b_s[36];
wire [35:0] b_din = b_s[35:0];

reg ctrl_odd_r;
reg [`DCF_PTR_W-1:0] wptr_r;
reg [`DCF_PTR_W-1:0] rptr_r;
reg [`DCF_CNT_W-1:0] count_r;
reg [`DCF_CNT_W-1:0] count_nxt;
reg full_st_r;
reg empty_st_r;
reg af_st_r;
reg ae_st_r;
reg [35:0] mail1_r;
reg [35:0] mail2_r;
reg [35:0] hold_r;
reg [35:0] fifo_out_r;
reg [1:0] part_r;
reg [1:0] size_lat_r;
reg endian_lat_r;
reg [4:0] ofs_r;
reg [1:0] fs_s1_r;
reg [1:0] fs_s2_r;
reg [1:0] cap_cnt_r;
wire [35:0] mem_rdata;

wire a_act = a_rise & ~a_sel_n & a_en; // R2 R9
wire a_fifo_wr = a_act & a_dir & ~a_mb & full_flag_n; // R25 R8
wire a_mail_wr = a_act & a_dir & a_mb & a_to_b_mail_flag_n; // R11 R12
wire a_mail_rd = a_act & ~a_dir & a_mb; // R15
wire b_act = b_rise & ~b_sel_n & b_en; // R2 R10
wire b_mbox = (b_size == `DCF_SIZE_MAIL);
wire b_mail_wr = b_act & b_dir & b_mbox & b_to_a_mail_flag_n; // R14
wire b_mail_rd = b_act & ~b_dir & b_mbox; // R13
wire b_fifo_rd = b_act & ~b_dir & ~b_mbox;
wire b_pop = b_fifo_rd & (part_r == 2'h0) & empty_flag_n; // R7
wire b_step = b_fifo_rd & (part_r != 2'h0);
wire [35:0] popped = swap(mem_rdata, b_swap); // R18 R26
wire odd = ctrl_odd_r; // R19

dcf_mem u_mem
(
   .pclk(pclk),
   .we(a_fifo_wr),
   .waddr(wptr_r),
   .wdata(a_din),
   .raddr(rptr_r),
   .rdata(mem_rdata)
);

always @*
begin
   case ({a_fifo_wr, b_pop})
      2'b10: count_nxt = count_r + 7'h01;
      2'b01: count_nxt = count_r - 7'h01;
      default: count_nxt = count_r;
   endcase
end

// store pointers, occupancy and flag pipelines
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      wptr_r <= 6'h00;
      rptr_r <= 6'h00;
      count_r <= 7'h00;
      full_st_r <= 1'b0;
      full_flag_n <= 1'b0; // R23
      af_st_r <= 1'b1;
      almost_full_flag_n <= 1'b1; // R23
      empty_st_r <= 1'b0;
      empty_flag_n <= 1'b0; // R23
      ae_st_r <= 1'b0;
      almost_empty_flag_n <= 1'b0; // R23
   end
   else
   begin
      if (a_fifo_wr)
         wptr_r <= wptr_r + 6'h01; // R1
      if (b_pop)
         rptr_r <= rptr_r + 6'h01; // R1
      count_r <= count_nxt;
      // a write that fills the store blocks the next write at once
      if (a_rise)
      begin
         full_st_r <= (count_nxt != `DCF_DEPTH); // R3
         full_flag_n <= (a_fifo_wr && count_nxt == `DCF_DEPTH) ? 1'b0 : full_st_r; // R8
         af_st_r <= ((`DCF_DEPTH - count_nxt) > {2'h0, ofs_r}); // R5
         almost_full_flag_n <= af_st_r; // R3
      end
      if (b_rise)
      begin
         empty_st_r <= (count_nxt != 7'h00); // R3
         empty_flag_n <= (b_pop && count_nxt == 7'h00) ? 1'b0 : empty_st_r; // R7
         ae_st_r <= (count_nxt > {2'h0, ofs_r}); // R4
         almost_empty_flag_n <= ae_st_r; // R3
      end
   end
end

// mailboxes: a new letter wins over a read in the same cycle
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      mail1_r <= 36'h0_0000_0000;
      mail2_r <= 36'h0_0000_0000;
      a_to_b_mail_flag_n <= 1'b1; // R23
      b_to_a_mail_flag_n <= 1'b1; // R23
   end
   else
   begin
      if (a_mail_wr)
         mail1_r <= a_din;
      if (b_mail_wr)
         mail2_r <= b_din;
      if (a_mail_wr)
         a_to_b_mail_flag_n <= 1'b0; // R12
      else if (b_mail_rd)
         a_to_b_mail_flag_n <= 1'b1; // R13
      if (b_mail_wr)
         b_to_a_mail_flag_n <= 1'b0; // R14
      else if (a_mail_rd)
         b_to_a_mail_flag_n <= 1'b1; // R15
   end
end

// port-b sizing: selects take hold one b edge after they are seen
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      size_lat_r <= `DCF_SIZE_LONG;
      endian_lat_r <= 1'b0;
      part_r <= 2'h0;
      hold_r <= 36'h0_0000_0000;
      fifo_out_r <= 36'h0_0000_0000;
   end
   else
   begin
      if (b_rise)
      begin
         size_lat_r <= b_size; // R16
         endian_lat_r <= b_endian_n;
      end
      if (b_pop)
      begin
         hold_r <= popped;
         fifo_out_r <= place(popped, size_lat_r, endian_lat_r, 2'h0); // R16 R17
         part_r <= (last_part(size_lat_r) == 2'h0) ? 2'h0 : 2'h1;
      end
      else if (b_step)
      begin
         fifo_out_r <= place(hold_r, size_lat_r, endian_lat_r, part_r); // R17
         part_r <= (part_r >= last_part(size_lat_r)) ? 2'h0 : part_r + 2'h1;
      end
   end
end

// pin outputs and passive parity checks
wire a_force = ~a_sel_n & a_en & ~a_dir & a_mb & a_pg;
wire b_force = ~b_sel_n & b_en & ~b_dir & b_mbox & b_pg;
reg [3:0] b_mask;

always @*
begin
   b_mask = 4'hf;
   if (!b_mbox && size_lat_r == `DCF_SIZE_WORD)
      b_mask = endian_lat_r ? 4'h3 : 4'hc;
   else if (!b_mbox && size_lat_r == `DCF_SIZE_BYTE)
      b_mask = endian_lat_r ? 4'h1 : 4'h8;
end

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      a_side_data_bus_out <= 36'h0_0000_0000;
      a_side_data_bus_oe <= 1'b0;
      a_side_parity_error_n <= 1'b1;
      b_side_data_bus_out <= 36'h0_0000_0000;
      b_side_data_bus_oe <= 1'b0;
      b_side_parity_error_n <= 1'b1;
   end
   else
   begin
      a_side_data_bus_oe <= ~a_sel_n & ~a_dir; // R9
      a_side_data_bus_out <= a_pg ? gen_par(mail2_r, odd) : mail2_r; // R11 R22
      a_side_parity_error_n <= a_force | ~par_err(a_din, odd, 4'hf); // R20 R21 R22
      b_side_data_bus_oe <= ~b_sel_n & ~b_dir; // R10
      if (b_mbox)
         b_side_data_bus_out <= b_pg ? gen_par(mail1_r, odd) : mail1_r; // R22
      else
         b_side_data_bus_out <= b_pg ? gen_par(fifo_out_r, odd) : fifo_out_r; // R22
      b_side_parity_error_n <= b_force | ~par_err(b_din, odd, b_mask); // R22
   end
end

// offset straps are taken a few cycles after release, once synchronised
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      fs_s1_r <= 2'h0;
      fs_s2_r <= 2'h0;
      cap_cnt_r <= 2'h0;
      ofs_r <= `DCF_OFS_RST;
   end
   else
   begin
      fs_s1_r <= {offset_select_hi, offset_select_lo};
      fs_s2_r <= fs_s1_r;
      if (cap_cnt_r != 2'h3)
         cap_cnt_r <= cap_cnt_r + 2'h1;
      if (cap_cnt_r == `DCF_CAP_DELAY)
      begin
         case (fs_s2_r) // R6 R24
            2'h3: ofs_r <= `DCF_OFS_HH;
            2'h2: ofs_r <= `DCF_OFS_HL;
            2'h1: ofs_r <= `DCF_OFS_LH;
            default: ofs_r <= `DCF_OFS_LL;
         endcase
      end
   end
end

// apb: zero wait states, read data latched in the setup cycle
reg [31:0] stat_w;
wire apb_setup = psel & ~penable;
wire hit_ctrl = (paddr == `DCF_ADDR_CTRL);
wire hit_stat = (paddr == `DCF_ADDR_STAT);

assign pready = psel & penable;

always @*
begin
   stat_w = 32'h0000_0000;
   stat_w[`DCF_ST_CNT_MSB:`DCF_ST_CNT_LSB] = count_r;
   stat_w[`DCF_ST_FULL] = full_flag_n;
   stat_w[`DCF_ST_EMPTY] = empty_flag_n;
   stat_w[`DCF_ST_AFULL] = almost_full_flag_n;
   stat_w[`DCF_ST_AEMPTY] = almost_empty_flag_n;
   stat_w[`DCF_ST_A_TO_B_MAIL_FLAG_N] = a_to_b_mail_flag_n;
   stat_w[`DCF_ST_B_TO_A_MAIL_FLAG_N] = b_to_a_mail_flag_n;
   stat_w[`DCF_ST_OFS_MSB:`DCF_ST_OFS_LSB] = ofs_r;
end

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      ctrl_odd_r <= `DCF_CTRL_RST;
   end
   else
   begin
      if (apb_setup)
      begin
         pslverr <= ~(hit_ctrl | hit_stat);
         if (!pwrite && hit_ctrl)
            prdata <= {31'h0000_0000, ctrl_odd_r};
         else if (!pwrite && hit_stat)
            prdata <= stat_w;
         else
            prdata <= 32'h0000_0000;
      end
      if (psel && penable && pwrite && hit_ctrl)
         ctrl_odd_r <= pwdata[`DCF_CTRL_ODD]; // R19
   end
end

endmodule

// *** dcf_top_props.sv ***
module dcf_top_props
(
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [11:0] paddr,
   input wire pready,
   input wire pslverr,
   // port a
   input wire write_port_select_n,
   input wire write_port_dir,
   input wire a_side_mailbox_select,
   input wire a_side_data_bus_oe,
   input wire full_flag_n,
   input wire almost_full_flag_n,
   input wire a_to_b_mail_flag_n,
   // port b
   input wire read_port_select_n,
   input wire read_port_dir,
   input wire bus_size_sel_lo,
   input wire bus_size_sel_hi,
   input wire b_side_data_bus_oe,
   input wire almost_empty_flag_n,
   input wire b_to_a_mail_flag_n
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // the bench holds port controls a few pclk past each port edge, so flags settle first
   wire a_mail = !write_port_select_n && a_side_mailbox_select;
   wire b_mail = !read_port_select_n && bus_size_sel_hi && bus_size_sel_lo;

   apb_ready_a: assert property (psel && penable |-> pready)
      else $error("pready low in access phase");
   bad_addr_a: assert property (psel && !penable && paddr != 12'h000 && paddr != 12'h004
      |=> pslverr) else $error("no error on unmapped address");
   flag_order_a: assert property (!almost_full_flag_n |-> almost_empty_flag_n)
      else $error("almost full and almost empty both active");
   full_cause_a: assert property ($fell(full_flag_n) |-> !write_port_select_n && write_port_dir)
      else $error("full flag fell without a write");
   a_drive_a: assert property ($rose(a_side_data_bus_oe) |-> !write_port_select_n && !write_port_dir)
      else $error("port a driven while not selected for read");
   b_drive_a: assert property ($rose(b_side_data_bus_oe) |-> !read_port_select_n && !read_port_dir)
      else $error("port b driven while not selected for read");
   ab_post_a: assert property ($fell(a_to_b_mail_flag_n) |-> a_mail && write_port_dir)
      else $error("a to b flag fell without a mail write");
   ab_clear_a: assert property ($rose(a_to_b_mail_flag_n) |-> b_mail && !read_port_dir)
      else $error("a to b flag rose without a mail read");
   ba_post_a: assert property ($fell(b_to_a_mail_flag_n) |-> b_mail && read_port_dir)
      else $error("b to a flag fell without a mail write");
   ba_clear_a: assert property ($rose(b_to_a_mail_flag_n) |-> a_mail && !write_port_dir)
      else $error("b to a flag rose without a mail read");
endmodule

bind dcf_top dcf_top_props i_props (.pclk, .presetn, .psel, .penable, .paddr, .pready,
   .pslverr, .write_port_select_n, .write_port_dir, .a_side_mailbox_select,
   .a_side_data_bus_oe, .full_flag_n, .almost_full_flag_n, .a_to_b_mail_flag_n,
   .read_port_select_n, .read_port_dir, .bus_size_sel_lo, .bus_size_sel_hi,
   .b_side_data_bus_oe, .almost_empty_flag_n, .b_to_a_mail_flag_n);

// *** dcf_port_host.sv ***
module dcf_port_host
(
   // free-running port clocks
   output logic a_clk,
   output logic b_clk,
   // port-a wire
   input logic a_oe,
   input logic [35:0] a_out,
   input logic [35:0] a_drv,
   output logic [35:0] a_wire,
   // port-b wire
   input logic b_oe,
   input logic [35:0] b_out,
   input logic [35:0] b_drv,
   output logic [35:0] b_wire
);
   timeunit 1ns;
   timeprecision 1ns;
   // odd offsets keep port edges off pclk edges; rates differ so phases drift
   initial
   begin
      a_clk = 0;
      b_clk = 0;
      #30;
      fork
         forever #200 a_clk = ~a_clk;
         #40 forever #250 b_clk = ~b_clk;
      join
   end
   // the host lets go of the wire whenever the device drives it
   assign a_wire = a_oe ? a_out : a_drv;
   assign b_wire = b_oe ? b_out : b_drv;
endmodule

// *** dcf_top_bench.sv ***
module dcf_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   wire [31:0] prdata;
   wire pready, pslverr, a_clk, b_clk, a_oe, b_oe;
   logic a_sel_n = 1, a_en = 0, a_dir = 0, a_mb = 0, a_pg = 0, b_pg = 0, fs_lo = 0, fs_hi = 1;
   logic b_sel_n = 1, b_en = 0, b_dir = 0, b_szl = 0, b_szh = 0, b_end_n = 0, b_swl = 0, b_swh = 0;
   logic [35:0] a_drv = 0, b_drv = 0;
   wire [35:0] a_in, a_out, b_in, b_out;
   wire full_n, af_n, mf1_n, pe_a_n, empty_n, ae_n, mf2_n, pe_b_n;
   int failures = 0, cmp_count = 0;

   always #50 pclk = ~pclk;

   dcf_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .offset_select_lo(fs_lo), .offset_select_hi(fs_hi),
      .write_port_clock(a_clk), .write_port_select_n(a_sel_n), .write_port_enable(a_en),
      .write_port_dir(a_dir), .a_side_mailbox_select(a_mb), .a_side_parity_gen(a_pg),
      .a_side_data_bus_in(a_in), .a_side_data_bus_out(a_out), .a_side_data_bus_oe(a_oe),
      .full_flag_n(full_n), .almost_full_flag_n(af_n), .a_to_b_mail_flag_n(mf1_n),
      .a_side_parity_error_n(pe_a_n), .read_port_clock(b_clk), .read_port_select_n(b_sel_n),
      .read_port_enable(b_en), .read_port_dir(b_dir), .bus_size_sel_lo(b_szl),
      .bus_size_sel_hi(b_szh), .endian_select_n(b_end_n), .swap_sel_lo(b_swl),
      .swap_sel_hi(b_swh), .b_side_parity_gen(b_pg), .b_side_data_bus_in(b_in),
      .b_side_data_bus_out(b_out), .b_side_data_bus_oe(b_oe), .empty_flag_n(empty_n),
      .almost_empty_flag_n(ae_n), .b_to_a_mail_flag_n(mf2_n), .b_side_parity_error_n(pe_b_n));

   dcf_port_host i_host (.a_clk(a_clk), .b_clk(b_clk), .a_oe(a_oe), .a_out(a_out),
      .a_drv(a_drv), .a_wire(a_in), .b_oe(b_oe), .b_out(b_out), .b_drv(b_drv), .b_wire(b_in));

   task chk(input logic [35:0] got, input logic [35:0] exp, input string msg);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask

   // controls stay set after the edge; only the enable drops
   task pa(input logic dir, input logic mb, input logic pg, input logic [35:0] d);
      @(negedge a_clk);
      @(posedge pclk);
      {a_sel_n, a_en, a_dir, a_mb, a_pg, a_drv} <= {1'b0, 1'b1, dir, mb, pg, d};
      @(posedge a_clk);
      @(negedge a_clk);
      @(posedge pclk);
      a_en <= 0;
      repeat (4) @(posedge pclk);
   endtask

   // one idle edge first: size and endian take effect one port-b edge late
   task pb(input logic dir, input logic [1:0] sz, input logic [1:0] sw, input logic en_n,
      input logic [35:0] d);
      @(negedge b_clk);
      @(posedge pclk);
      {b_sel_n, b_en, b_dir, b_szh, b_szl, b_swh, b_swl, b_end_n, b_drv} <=
         {1'b0, 1'b0, dir, sz, sw, en_n, d};
      @(negedge b_clk);
      @(posedge pclk);
      b_en <= 1;
      @(negedge b_clk);
      @(posedge pclk);
      b_en <= 0;
      repeat (4) @(posedge pclk);
   endtask

   function logic [35:0] wv(input int i);
      return 36'h5_0000_0000 ^ (i * 36'h0_1357_9bdf);
   endfunction

   function logic [35:0] swp(input logic [35:0] w, input logic [1:0] m);
      case (m)
         2'h1: return {w[8:0], w[17:9], w[26:18], w[35:27]};
         2'h2: return {w[17:0], w[35:18]};
         2'h3: return {w[26:18], w[35:27], w[8:0], w[17:9]};
         default: return w;
      endcase
   endfunction

   task t_reset;
      chk({full_n, empty_n, ae_n, af_n, mf1_n, mf2_n}, 6'h07, "reset flags");
      repeat (3) @(posedge a_clk);
      repeat (4) @(posedge pclk);
      chk(full_n, 1, "full after reset");
      apb(0, 12'h004, 0);
      chk(rd[20:16], 5'h0c, "captured offset");
      apb(0, 12'h008, 0);
      chk({err, rd}, {1'b1, 32'h0000_0000}, "unmapped read");
      $display("test reset done");
   endtask

   task t_fill;
      for (int i = 0; i < 65; i++)
      begin
         pa(1, 0, 0, wv(i));
         if (i == 11 || i == 12)
         begin
            repeat (12) @(posedge pclk);
            chk({empty_n, ae_n}, {1'b1, i == 12}, "almost empty edge");
         end
      end
      chk({full_n, af_n}, 2'b00, "full flags");
      for (int i = 0; i < 64; i++)
      begin
         pb(0, 2'h0, 2'h0, 0, 0);
         chk(b_out, wv(i), "store order");
         if (i == 11 || i == 12)
         begin
            repeat (12) @(posedge pclk);
            chk({full_n, af_n}, {1'b1, i == 12}, "almost full edge");
         end
      end
      chk({empty_n, ae_n}, 2'b00, "drained flags");
      $display("test fill done");
   endtask

   task t_shape;
      logic [35:0] w;
      w = 36'h9_1234_5678;
      for (int m = 0; m < 6; m++)
         pa(1, 0, 0, w);
      for (int m = 0; m < 4; m++)
      begin
         pb(0, 2'h0, m[1:0], 0, 0);
         chk(b_out, swp(w, m[1:0]), "swap mode");
      end
      for (int k = 0; k < 4; k++)
      begin
         pb(0, 2'h2, 2'h0, 0, 0);
         chk(b_out, {w[35-9*k -: 9], 27'h0}, "byte big endian");
      end
      for (int k = 0; k < 2; k++)
      begin
         pb(0, 2'h1, 2'h0, 1, 0);
         chk(b_out, {18'h0, w[18*k +: 18]}, "word little endian");
      end
      $display("test shape done");
   endtask

   task t_mail;
      pa(1, 1, 0, 36'h1_1111_2222);
      pa(1, 1, 0, 36'h3_3333_4444);
      chk(mf1_n, 0, "a to b posted");
      pb(0, 2'h3, 2'h0, 0, 0);
      chk({mf1_n, b_out}, {1'b1, 36'h1_1111_2222}, "a to b read");
      pb(1, 2'h3, 2'h0, 0, 36'h5_5555_6666);
      pb(1, 2'h3, 2'h0, 0, 36'h7_7777_8888);
      chk(mf2_n, 0, "b to a posted");
      pa(0, 1, 0, 0);
      chk({mf2_n, a_oe, a_out}, {2'b11, 36'h5_5555_6666}, "b to a read");
      $display("test mail done");
   endtask

   task t_parity;
      pa(1, 0, 0, 36'h0_0804_0201);
      chk(pe_a_n, 0, "even parity error");
      pb(1, 2'h3, 2'h0, 0, 36'h0_0804_0201);
      chk(pe_b_n, 0, "port b parity error");
      apb(1, 12'h000, 1);
      repeat (4) @(posedge pclk);
      chk({pe_a_n, pe_b_n}, 2'h3, "odd parity clean");
      apb(0, 12'h000, 0);
      chk(rd, 1, "control readback");
      apb(1, 12'h000, 0);
      pa(0, 1, 1, 0);
      chk(pe_a_n, 1, "error forced off");
      for (int k = 0; k < 4; k++)
         chk(^a_out[9*k +: 9], 0, "generated parity");
      b_pg <= 1;
      pa(1, 1, 0, 36'h0_0804_0201);
      pb(0, 2'h3, 2'h0, 0, 0);
      for (int k = 0; k < 4; k++)
         chk(^b_out[9*k +: 9], 0, "port b generated parity");
      $display("test parity done");
   endtask

   // second reset with other straps: offset, flags and count start over
   task t_offset;
      {fs_hi, fs_lo} <= 2'h3;
      presetn <= 0;
      repeat (4) @(posedge a_clk);
      repeat (4) @(posedge b_clk);
      @(posedge pclk);
      presetn <= 1;
      repeat (4) @(posedge pclk);
      apb(0, 12'h004, 0);
      chk({rd[20:16], rd[13:9], rd[6:0]}, {5'h10, 5'h1a, 7'h00}, "state after reset");
      $display("test offset done");
   endtask

   task wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      repeat (10) @(posedge pclk);
      // the port clocks are slow: reset also spans four edges of each
      fork
         repeat (4) @(posedge a_clk);
         repeat (4) @(posedge b_clk);
      join
      @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_reset;
      t_fill;
      t_shape;
      t_mail;
      t_parity;
      t_offset;
      wrap_up;
   end

   // the full run needs about a quarter of this span
   initial
   begin
      #1_000_000;
      failures++;
      wrap_up;
   end
endmodule
